// [design/ims_sequencer.v]
// i2c master sequencer: repeated start, byte transmit and receive, acknowledge and stop, with apb registers
`timescale 1ns/1ps
`include "ims_defines.vh"

// Functional notes
// - repeated start: scl low, load, release sda
// - sda high: release scl, wait, sda low
// - finish: scl low, clear rs_enable, flags
// - rs_enable ignored while another event runs
// - repeated start collision on sda or scl
// - buffer write during events sets write collision
// - ctrl low bits locked until start completes
// - buffer write sets full flag, starts sending
// - sda changes with scl low, timed halves
// - eighth falling edge clears full, releases sda
// - ninth falling edge samples ack status
// - after ninth clock: irq, hold scl low
// - write during send collides; quick rewrite updates
// - receive_enable honoured only when sequencer idle
// - receive: toggle scl per rollover, shift sda
// - eighth received clock: buffer, flags, scl low
// - receive mode buffer read clears full flag
// - byte completes with full set: overflow
// - acknowledge: scl low, drive ack_data_value
// - acknowledge: release scl, wait, low, done
// - stop: sda low, release scl, release sda
// - stop seen, then period later irq, done
// - released scl holds counter until sampled high
// - counter decrements twice per instruction cycle
module ims_sequencer #(
	parameter RELOAD_W = 7
) (
	input wire pclk,
	input wire presetn,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [7:0] paddr,
	input wire [31:0] pwdata,
	output reg [31:0] prdata_r,
	output reg pready_r,
	output reg pslverr_r,
	input wire scl_in,
	output reg scl_out_r,
	output reg scl_oe_r,
	input wire sda_in,
	output reg sda_out_r,
	output reg sda_oe_r
);
	localparam [4:0] S_IDLE = 5'd0;
	localparam [4:0] S_RS_A = 5'd1;
	localparam [4:0] S_RS_B = 5'd2;
	localparam [4:0] S_RS_C = 5'd3;
	localparam [4:0] S_RS_D = 5'd4;
	localparam [4:0] S_RS_E = 5'd5;
	localparam [4:0] S_TX_A = 5'd6;
	localparam [4:0] S_TX_B = 5'd7;
	localparam [4:0] S_TX_C = 5'd8;
	localparam [4:0] S_TX_D = 5'd9;
	localparam [4:0] S_RX_A = 5'd10;
	localparam [4:0] S_RX_B = 5'd11;
	localparam [4:0] S_RX_C = 5'd12;
	localparam [4:0] S_RX_D = 5'd13;
	localparam [4:0] S_AK_A = 5'd14;
	localparam [4:0] S_AK_B = 5'd15;
	localparam [4:0] S_AK_C = 5'd16;
	localparam [4:0] S_AK_D = 5'd17;
	localparam [4:0] S_ST_A = 5'd18;
	localparam [4:0] S_ST_B = 5'd19;
	localparam [4:0] S_ST_C = 5'd20;
	localparam [4:0] S_ST_D = 5'd21;
	localparam [4:0] S_ST_E = 5'd22;
	localparam [4:0] S_ST_F = 5'd23;
	localparam [7:0] GRACE_CLKS = `IMS_WRITE_COLLISION_FLAG_GRACE_CLKS;

	reg [4:0] state_r;
	reg [1:0] scl_sync_r;
	reg [1:0] sda_sync_r;
	reg sda_prev_r;
	reg [RELOAD_W-1:0] reload_r;
	reg [7:0] buf_r;
	reg [7:0] shift_r;
	reg [3:0] bitn_r;
	reg [7:0] grace_r;
	reg ld_r;
	reg rs_en_r;
	reg stop_en_r;
	reg rcv_en_r;
	reg ack_en_r;
	reg ack_dt_r;
	reg ack_stat_r;
	reg bf_r;
	reg start_seen_r;
	reg stop_seen_r;
	reg xfer_irq_r;
	reg write_collision_flag_r;
	reg ovf_r;
	reg bcol_r;
	reg rx_mode_r;
	reg [31:0] rdata_nxt;
	reg map_hit;
	wire scl_s;
	wire sda_s;
	wire exp;
	wire access;
	wire wr_ctrl;
	wire wr_buf;
	wire wr_reload;
	wire wr_flags;
	wire rd_buf;
	wire seq_idle;
	wire coll;

	// pins cross into pclk through two flops before anything looks at them
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			scl_sync_r <= 2'b11;
			sda_sync_r <= 2'b11;
			sda_prev_r <= 1'b1;
		end else begin
			scl_sync_r <= {scl_sync_r[0], scl_in};
			sda_sync_r <= {sda_sync_r[0], sda_in};
			sda_prev_r <= sda_sync_r[1];
		end
	end
	assign scl_s = scl_sync_r[1];
	assign sda_s = sda_sync_r[1];

	ims_baud_counter #(
		.WIDTH(RELOAD_W),
		.TICK_DIV(`IMS_TICK_DIV)
	) u_baud (
		.pclk(pclk),
		.presetn(presetn),
		.load(ld_r),
		.clear(coll),
		.reload(reload_r),
		.expired_r(exp)
	);

	// apb decode; no wait states, yet read data and ready come from flops
	assign access = psel && penable && pready_r;
	assign wr_ctrl = access && pwrite && (paddr == `IMS_ADDR_CTRL_TWO);
	assign wr_buf = access && pwrite && (paddr == `IMS_ADDR_BUFFER);
	assign wr_reload = access && pwrite && (paddr == `IMS_ADDR_RELOAD);
	assign wr_flags = access && pwrite && (paddr == `IMS_ADDR_FLAGS);
	assign rd_buf = access && !pwrite && (paddr == `IMS_ADDR_BUFFER);
	assign seq_idle = (state_r == S_IDLE) && !rs_en_r && !stop_en_r && !rcv_en_r && !ack_en_r;

	// repeated start bus collision checks
	assign coll = (state_r == S_RS_B && exp && !sda_s) ||
		(state_r == S_RS_C && scl_s && !sda_s) ||
		(state_r == S_RS_D && !scl_s);

	// read mux, unmapped addresses read zero and answer with an error
	always @* begin
		rdata_nxt = 32'h0000_0000;
		map_hit = 1'b1;
		case (paddr)
			`IMS_ADDR_CTRL_TWO: begin
				rdata_nxt[`IMS_CT_RS_EN] = rs_en_r;
				rdata_nxt[`IMS_CT_STOP_EN] = stop_en_r;
				rdata_nxt[`IMS_CT_RCV_EN] = rcv_en_r;
				rdata_nxt[`IMS_CT_ACK_EN] = ack_en_r;
				rdata_nxt[`IMS_CT_ACK_DT] = ack_dt_r;
				rdata_nxt[`IMS_CT_ACK_STAT] = ack_stat_r;
			end
			`IMS_ADDR_STATUS: begin
				rdata_nxt[`IMS_ST_BUF_FULL] = bf_r;
				rdata_nxt[`IMS_ST_START_SEEN] = start_seen_r;
				rdata_nxt[`IMS_ST_STOP_SEEN] = stop_seen_r;
			end
			`IMS_ADDR_BUFFER: rdata_nxt[7:0] = buf_r;
			`IMS_ADDR_RELOAD: rdata_nxt[RELOAD_W-1:0] = reload_r;
			`IMS_ADDR_FLAGS: begin
				rdata_nxt[`IMS_FL_XFER_IRQ] = xfer_irq_r;
				rdata_nxt[`IMS_FL_WRITE_COLLISION_FLAG] = write_collision_flag_r;
				rdata_nxt[`IMS_FL_RX_OVF] = ovf_r;
				rdata_nxt[`IMS_FL_BUS_COL] = bcol_r;
			end
			default: map_hit = 1'b0;
		endcase
	end

	// apb answer: ready rises in the cycle after setup, drops after the access
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready_r <= 1'b0;
			pslverr_r <= 1'b0;
			prdata_r <= 32'h0000_0000;
		end else if (psel && !penable) begin
			pready_r <= 1'b1;
			pslverr_r <= !map_hit;
			prdata_r <= pwrite ? 32'h0000_0000 : rdata_nxt;
		end else begin
			pready_r <= 1'b0;
			pslverr_r <= 1'b0;
		end
	end

	// baud reload register is free to change; it takes effect at the next reload
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			reload_r <= `IMS_RELOAD_RESET;
		end else if (wr_reload) begin
			reload_r <= pwdata[RELOAD_W-1:0];
		end
	end

	// bus condition detectors on the synchronised lines
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			start_seen_r <= 1'b0;
			stop_seen_r <= 1'b0;
		end else if (scl_s && sda_prev_r && !sda_s) begin
			start_seen_r <= 1'b1;
			stop_seen_r <= 1'b0;
		end else if (scl_s && !sda_prev_r && sda_s) begin
			stop_seen_r <= 1'b1;
			start_seen_r <= 1'b0;
		end
	end

	// sequencer; software clears go first so a hardware set in the same cycle wins
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_r <= S_IDLE;
			scl_out_r <= 1'b0;
			sda_out_r <= 1'b0;
			scl_oe_r <= 1'b0;
			sda_oe_r <= 1'b0;
			buf_r <= 8'h00;
			shift_r <= 8'h00;
			bitn_r <= 4'h0;
			grace_r <= 8'h00;
			ld_r <= 1'b0;
			rs_en_r <= 1'b0;
			stop_en_r <= 1'b0;
			rcv_en_r <= 1'b0;
			ack_en_r <= 1'b0;
			ack_dt_r <= 1'b0;
			ack_stat_r <= 1'b0;
			bf_r <= 1'b0;
			xfer_irq_r <= 1'b0;
			write_collision_flag_r <= 1'b0;
			ovf_r <= 1'b0;
			bcol_r <= 1'b0;
			rx_mode_r <= 1'b0;
		end else begin
			ld_r <= 1'b0;
			if (grace_r != 8'h00) begin
				grace_r <= grace_r - 8'h01;
			end
			if (wr_flags) begin
				if (pwdata[`IMS_FL_XFER_IRQ]) xfer_irq_r <= 1'b0;
				if (pwdata[`IMS_FL_WRITE_COLLISION_FLAG]) write_collision_flag_r <= 1'b0;
				if (pwdata[`IMS_FL_RX_OVF]) ovf_r <= 1'b0;
				if (pwdata[`IMS_FL_BUS_COL]) bcol_r <= 1'b0;
			end
			if (rd_buf && rx_mode_r) begin
				bf_r <= 1'b0;
			end
			// enable bits only land when nothing else is running or queued
			if (wr_ctrl) begin
				ack_dt_r <= pwdata[`IMS_CT_ACK_DT];
				if (seq_idle) begin
					rs_en_r <= pwdata[`IMS_CT_RS_EN];
					stop_en_r <= pwdata[`IMS_CT_STOP_EN];
					rcv_en_r <= pwdata[`IMS_CT_RCV_EN];
					ack_en_r <= pwdata[`IMS_CT_ACK_EN];
				end
			end
			// buffer writes: start a byte when idle, otherwise collide
			if (wr_buf) begin
				if (seq_idle && !(wr_ctrl && pwdata[4:1] != 4'h0)) begin
					buf_r <= pwdata[7:0];
					shift_r <= pwdata[7:0];
					bf_r <= 1'b1;
					bitn_r <= 4'h0;
					rx_mode_r <= 1'b0;
					grace_r <= GRACE_CLKS;
					scl_oe_r <= 1'b1;
					state_r <= S_TX_A;
				end else if (grace_r != 8'h00 && !rx_mode_r) begin
					write_collision_flag_r <= 1'b1;
					buf_r <= pwdata[7:0];
					if (bitn_r == 4'h0) begin
						shift_r <= pwdata[7:0]; // late rewrite may corrupt the byte on the wire
					end
				end else begin
					write_collision_flag_r <= 1'b1;
				end
			end
			case (state_r)
				S_IDLE: begin
					if (rs_en_r) begin
						scl_oe_r <= 1'b1;
						state_r <= S_RS_A;
					end else if (stop_en_r) begin
						sda_oe_r <= 1'b1;
						state_r <= S_ST_A;
					end else if (ack_en_r) begin
						scl_oe_r <= 1'b1;
						state_r <= S_AK_A;
					end else if (rcv_en_r) begin
						bitn_r <= 4'h0;
						rx_mode_r <= 1'b1;
						state_r <= S_RX_A;
					end
				end
				S_RS_A: begin
					if (!scl_s) begin
						sda_oe_r <= 1'b0;
						ld_r <= 1'b1;
						state_r <= S_RS_B;
					end
				end
				S_RS_B: begin
					if (exp && sda_s) begin
						scl_oe_r <= 1'b0;
						state_r <= S_RS_C;
					end
				end
				S_RS_C: begin
					if (scl_s && sda_s) begin
						ld_r <= 1'b1;
						state_r <= S_RS_D;
					end
				end
				S_RS_D: begin
					if (exp) begin
						sda_oe_r <= 1'b1;
						ld_r <= 1'b1;
						state_r <= S_RS_E;
					end
				end
				S_RS_E: begin
					if (exp) begin
						scl_oe_r <= 1'b1;
						rs_en_r <= 1'b0;
						xfer_irq_r <= 1'b1;
						state_r <= S_IDLE;
					end
				end
				S_TX_A: begin
					sda_oe_r <= (bitn_r == 4'h8) ? 1'b0 : !shift_r[7];
					ld_r <= 1'b1;
					state_r <= S_TX_B;
				end
				S_TX_B: begin
					if (exp) begin
						scl_oe_r <= 1'b0;
						state_r <= S_TX_C;
					end
				end
				S_TX_C: begin
					if (scl_s) begin
						ld_r <= 1'b1;
						state_r <= S_TX_D;
					end
				end
				S_TX_D: begin
					if (exp) begin
						scl_oe_r <= 1'b1;
						if (bitn_r == 4'h8) begin
							ack_stat_r <= sda_s;
							xfer_irq_r <= 1'b1;
							state_r <= S_IDLE;
						end else begin
							if (bitn_r == 4'h7) begin
								bf_r <= 1'b0;
							end
							bitn_r <= bitn_r + 4'h1;
							shift_r <= {shift_r[6:0], 1'b0};
							state_r <= S_TX_A;
						end
					end
				end
				S_RX_A: begin
					sda_oe_r <= 1'b0;
					scl_oe_r <= 1'b1;
					ld_r <= 1'b1;
					state_r <= S_RX_B;
				end
				S_RX_B: begin
					if (exp) begin
						scl_oe_r <= 1'b0;
						state_r <= S_RX_C;
					end
				end
				S_RX_C: begin
					if (scl_s) begin
						ld_r <= 1'b1;
						state_r <= S_RX_D;
					end
				end
				S_RX_D: begin
					if (exp) begin
						scl_oe_r <= 1'b1;
						shift_r <= {shift_r[6:0], sda_s};
						if (bitn_r == 4'h7) begin
							rcv_en_r <= 1'b0;
							buf_r <= {shift_r[6:0], sda_s};
							bf_r <= 1'b1;
							if (bf_r) ovf_r <= 1'b1; // set only, wins over a same-cycle software clear
							xfer_irq_r <= 1'b1;
							state_r <= S_IDLE;
						end else begin
							bitn_r <= bitn_r + 4'h1;
							ld_r <= 1'b1;
							state_r <= S_RX_B;
						end
					end
				end
				S_AK_A: begin
					sda_oe_r <= !ack_dt_r;
					ld_r <= 1'b1;
					state_r <= S_AK_B;
				end
				S_AK_B: begin
					if (exp) begin
						scl_oe_r <= 1'b0;
						state_r <= S_AK_C;
					end
				end
				S_AK_C: begin
					if (scl_s) begin
						ld_r <= 1'b1;
						state_r <= S_AK_D;
					end
				end
				S_AK_D: begin
					if (exp) begin
						scl_oe_r <= 1'b1;
						ack_en_r <= 1'b0;
						xfer_irq_r <= 1'b1;
						state_r <= S_IDLE;
					end
				end
				S_ST_A: begin
					if (!sda_s) begin
						ld_r <= 1'b1;
						state_r <= S_ST_B;
					end
				end
				S_ST_B: begin
					if (exp) begin
						scl_oe_r <= 1'b0;
						state_r <= S_ST_C;
					end
				end
				S_ST_C: begin
					if (scl_s) begin
						ld_r <= 1'b1;
						state_r <= S_ST_D;
					end
				end
				S_ST_D: begin
					if (exp) begin
						sda_oe_r <= 1'b0;
						state_r <= S_ST_E;
					end
				end
				S_ST_E: begin
					if (sda_s && scl_s) begin
						ld_r <= 1'b1;
						state_r <= S_ST_F;
					end
				end
				S_ST_F: begin
					if (exp) begin
						stop_en_r <= 1'b0;
						xfer_irq_r <= 1'b1;
						state_r <= S_IDLE;
					end
				end
				default: state_r <= S_IDLE;
			endcase
			// a lost repeated start releases the bus and aborts
			if (coll) begin
				bcol_r <= 1'b1;
				rs_en_r <= 1'b0;
				scl_oe_r <= 1'b0;
				sda_oe_r <= 1'b0;
				ld_r <= 1'b0;
				state_r <= S_IDLE;
			end
		end
	end
endmodule // ims_sequencer

// [design/ims_defines.vh]
// register map, field positions, reset values and timing counts of the i2c master sequencer
`ifndef IMS_DEFINES_VH
`define IMS_DEFINES_VH

// apb byte addresses
`define IMS_ADDR_CTRL_TWO 8'h00
`define IMS_ADDR_STATUS 8'h04
`define IMS_ADDR_BUFFER 8'h08
`define IMS_ADDR_RELOAD 8'h0c
`define IMS_ADDR_FLAGS 8'h10

// ctrl_two_reg fields
`define IMS_CT_RS_EN 1
`define IMS_CT_STOP_EN 2
`define IMS_CT_RCV_EN 3
`define IMS_CT_ACK_EN 4
`define IMS_CT_ACK_DT 5
`define IMS_CT_ACK_STAT 6

// port_status_reg fields
`define IMS_ST_BUF_FULL 0
`define IMS_ST_START_SEEN 3
`define IMS_ST_STOP_SEEN 4

// flag register fields, write one to clear
`define IMS_FL_XFER_IRQ 0
`define IMS_FL_WRITE_COLLISION_FLAG 1
`define IMS_FL_RX_OVF 2
`define IMS_FL_BUS_COL 3

// reset values
`define IMS_RELOAD_RESET 7'h09

// baud counter decrements on every second pclk, two decrements per instruction cycle
`define IMS_TICK_DIV 2
// instruction cycle is two baud ticks
`define IMS_TCY_CLKS 4
// rewrite window after a transmit buffer write, in instruction cycles
`define IMS_WRITE_COLLISION_FLAG_GRACE_TCY 2
`define IMS_WRITE_COLLISION_FLAG_GRACE_CLKS (`IMS_WRITE_COLLISION_FLAG_GRACE_TCY * `IMS_TCY_CLKS)

`endif

// [design/ims_baud_counter.v]
// reloadable down-counter that times one baud period of the i2c sequencer
`timescale 1ns/1ps
module ims_baud_counter #(
	parameter WIDTH = 7,
	parameter TICK_DIV = 2
) (
	input wire pclk,
	input wire presetn,
	input wire load,
	input wire clear,
	input wire [WIDTH-1:0] reload,
	output reg expired_r
);
	reg [3:0] div_r;
	reg [WIDTH-1:0] cnt_r;
	reg busy_r;
	wire tick;

	// divider giving the decrement enable
	assign tick = (div_r == TICK_DIV[3:0] - 4'h1);

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			div_r <= 4'h0;
		end else if (tick) begin
			div_r <= 4'h0;
		end else begin
			div_r <= div_r + 4'h1;
		end
	end

	// counts down to zero, pulses expired, then stops until reloaded
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt_r <= {WIDTH{1'b0}};
			busy_r <= 1'b0;
			expired_r <= 1'b0;
		end else if (clear) begin
			cnt_r <= {WIDTH{1'b0}};
			busy_r <= 1'b0;
			expired_r <= 1'b0;
		end else if (load) begin
			cnt_r <= reload;
			busy_r <= (reload != {WIDTH{1'b0}});
			expired_r <= (reload == {WIDTH{1'b0}}); // zero reload is unsupported, expire at once
		end else if (busy_r && tick) begin
			cnt_r <= cnt_r - {{(WIDTH-1){1'b0}}, 1'b1};
			busy_r <= (cnt_r != {{(WIDTH-1){1'b0}}, 1'b1});
			expired_r <= (cnt_r == {{(WIDTH-1){1'b0}}, 1'b1});
		end else begin
			expired_r <= 1'b0;
		end
	end
endmodule // ims_baud_counter

// [verification/ims_properties.sv]
// concurrent checks on the ports of the i2c master sequencer
`timescale 1ns/1ps
module ims_properties (
	input wire pclk,
	input wire presetn,
	input wire psel,
	input wire penable,
	input wire [7:0] paddr,
	input wire pready_r,
	input wire pslverr_r,
	input wire scl_in,
	input wire scl_oe_r,
	input wire scl_out_r,
	input wire sda_oe_r,
	input wire sda_out_r
);
	// one domain, so clock and reset are given once
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	// apb answers in the cycle after setup, for one cycle only
	chk_ready_setup: assert property (psel && !penable |=> pready_r) else $error("no ready after setup");
	chk_ready_pulse: assert property (pready_r |=> !pready_r) else $error("ready longer than one cycle");
	chk_slverr_map: assert property (psel && !penable && paddr > 8'h10 |=> pslverr_r)
		else $error("unmapped address not refused");
	// lines are only pulled low, never driven high
	chk_drive_zero: assert property (!scl_out_r && !sda_out_r) else $error("line driven high");
	// both lines free right after reset
	chk_reset_free: assert property ($rose(presetn) |-> !scl_oe_r && !sda_oe_r && !pready_r)
		else $error("lines held after reset");
	// a pulled clock stays low for at least eight cycles
	chk_low_phase: assert property ($rose(scl_oe_r) |=> scl_oe_r [*8]) else $error("scl low phase short");
	// high time counts only from scl really seen high, so stretching is honoured
	chk_high_phase: assert property ($rose(scl_in) && !scl_oe_r |=> !scl_oe_r [*8])
		else $error("scl high phase short");
	// sda pulled while scl free is a start: hold it, then pull scl a period later
	chk_start_hold: assert property ($rose(sda_oe_r) && !scl_oe_r |-> sda_oe_r throughout (##[8:80] scl_oe_r))
		else $error("start condition malformed");
endmodule // ims_properties

bind ims_sequencer ims_properties chk (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
	.paddr(paddr), .pready_r(pready_r), .pslverr_r(pslverr_r), .scl_in(scl_in), .scl_oe_r(scl_oe_r),
	.scl_out_r(scl_out_r), .sda_oe_r(sda_oe_r), .sda_out_r(sda_out_r));

// [verification/ims_slave_model.sv]
// behavioural i2c slave on the far side of the sequencer
`timescale 1ns/1ps
module ims_slave_model (
	input wire scl,
	input wire sda,
	input wire ack_en,
	input wire rd_mode,
	input wire [7:0] rd_byte,
	input wire hold_scl,
	output logic sda_oe,
	output logic scl_oe,
	output logic [7:0] got
);
	int cnt = 0;
	logic scl_q = 1'b1;
	logic sda_q = 1'b1;
	// one process owns the bit count: start or stop restarts framing, the start's own scl fall brings it to zero;
	// data bits are taken while scl is high, the ack clock is skipped
	always @(scl or sda) begin
		if (scl === 1'b1 && scl_q === 1'b1 && sda !== sda_q) cnt = -1;
		else if (scl === 1'b0 && scl_q === 1'b1) cnt = (cnt == 8) ? 0 : cnt + 1;
		else if (scl === 1'b1 && scl_q === 1'b0 && cnt < 8) got = {got[6:0], sda};
		scl_q = scl;
		sda_q = sda;
	end
	// reads send msb first and free sda for the master's ack
	assign sda_oe = rd_mode ? (cnt >= 0 && cnt < 8 && !rd_byte[7-cnt]) : (cnt == 8 && ack_en);
	// stretching is commanded by the bench
	assign scl_oe = hold_scl;
endmodule // ims_slave_model

// [verification/ims_sequencer_tb_top.sv]
// self-checking bench for the i2c master sequencer
`timescale 1ns/1ps
`include "ims_defines.vh"
module ims_sequencer_tb_top;
	localparam CT = `IMS_ADDR_CTRL_TWO, ST = `IMS_ADDR_STATUS, BU = `IMS_ADDR_BUFFER;
	localparam RL = `IMS_ADDR_RELOAD, FL = `IMS_ADDR_FLAGS;
	logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, err;
	logic [7:0] paddr = 8'h00, rd_byte = 8'h00;
	logic [31:0] pwdata = 32'h0, rd;
	logic ack_en = 1, rd_mode = 0, hold_scl = 0;
	wire [31:0] prdata;
	wire pready, pslverr, scl_oe, sda_oe, m_scl_oe, m_sda_oe;
	wire [7:0] got;
	// open-drain lines with pull-ups
	wire scl = !(scl_oe | m_scl_oe);
	wire sda = !(sda_oe | m_sda_oe);
	int n_mismatch = 0, n_checks = 0, i, n;

	initial forever #10 pclk = ~pclk;

	ims_sequencer dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata_r(prdata), .pready_r(pready), .pslverr_r(pslverr),
		.scl_in(scl), .scl_out_r(), .scl_oe_r(scl_oe), .sda_in(sda), .sda_out_r(), .sda_oe_r(sda_oe));
	ims_slave_model slave (.scl(scl), .sda(sda), .ack_en(ack_en), .rd_mode(rd_mode), .rd_byte(rd_byte),
		.hold_scl(hold_scl), .sda_oe(m_sda_oe), .scl_oe(m_scl_oe), .got(got));

	task wrap_up;
		$display("checks %0d mismatches %0d", n_checks, n_mismatch);
		if (n_mismatch == 0 && n_checks > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask

	task chk(input string what, input logic [31:0] exp, input logic [31:0] seen);
		n_checks++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("wrong value %s expected %h seen %h", what, exp, seen);
		end
	endtask

	// one apb transfer; read data and error taken at the edge where ready is sampled
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int k;
		@(posedge pclk);
		psel <= 1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1;
		k = 0;
		do begin
			@(posedge pclk);
			k++;
		end while (pready !== 1'b1 && k < 50);
		if (k >= 50) begin
			n_mismatch++;
			wrap_up;
		end
		rd = prdata;
		err = pslverr;
		psel <= 0;
		penable <= 0;
	endtask

	task rdchk(input string what, input logic [7:0] a, input logic [31:0] exp);
		apb(0, a, 32'h0);
		chk(what, exp, rd);
	endtask

	// poll a register until the masked bits reach a value
	task wait_val(input logic [7:0] a, input logic [31:0] m, input logic [31:0] v);
		int k;
		for (k = 0; k < 400; k++) begin
			apb(0, a, 32'h0);
			if ((rd & m) === v) return;
		end
		n_mismatch++;
		wrap_up;
	endtask

	task wait_scl(input logic v);
		int k;
		for (k = 0; scl_oe !== v; k++) begin
			if (k == 300) begin
				n_mismatch++;
				wrap_up;
			end
			@(posedge pclk);
		end
	endtask

	initial begin
		repeat (4) @(posedge pclk);
		presetn <= 1;
		// reset values, buffer left out
		for (i = 0; i < 5; i++) if (i != 2) rdchk("reset reg", 8'(4 * i), i == 3 ? `IMS_RELOAD_RESET : 0);
		apb(0, 8'h14, 32'h0);
		chk("slverr", 1, err);
		chk("unmapped", 0, rd);
		// repeated start with queued events refused
		apb(1, CT, 32'h2);
		apb(1, CT, 32'h4);
		apb(1, BU, 32'h77);
		rdchk("ctrl busy", CT, 32'h2);
		wait_val(CT, 32'h2, 32'h0);
		rdchk("start seen", ST, 32'h8);
		rdchk("rs flags", FL, 32'h3);
		rdchk("rs buffer", BU, 32'h0);
		chk("rs lines", 2'b00, {scl, sda});
		// acked transmit; late write and enables refused while busy
		apb(1, FL, 32'hf);
		apb(1, BU, 32'ha5);
		rdchk("bf set", ST, 32'h9);
		repeat (20) @(posedge pclk);
		apb(1, CT, 32'ha);
		apb(1, BU, 32'h0f);
		rdchk("ignored", CT, 32'h0);
		rdchk("late write", BU, 32'ha5);
		rdchk("late write_collision_flag", FL, 32'h2);
		wait_val(FL, 32'h1, 32'h1);
		chk("sent", 8'ha5, got);
		rdchk("acked", CT, 32'h0);
		rdchk("bf clear", ST, 32'h8);
		chk("scl held", 0, scl);
		// not acked, with the first clock stretched by the slave
		ack_en <= 0;
		apb(1, FL, 32'hf);
		apb(1, BU, 32'h3c);
		hold_scl <= 1;
		repeat (60) @(posedge pclk);
		chk("scl freed", 0, scl_oe);
		hold_scl <= 0;
		for (n = 0; !scl && n < 10; n++) @(posedge pclk);
		for (n = 0; scl && n < 500; n++) @(posedge pclk);
		chk("high time", 1, n >= 2 * `IMS_RELOAD_RESET);
		wait_val(FL, 32'h1, 32'h1);
		rdchk("nack", CT, 32'h40);
		chk("nack byte", 8'h3c, got);
		// quick rewrite replaces the byte but still flags
		ack_en <= 1;
		apb(1, FL, 32'hf);
		apb(1, BU, 32'h11);
		apb(1, BU, 32'h5a);
		rdchk("rewrite", BU, 32'h5a);
		rdchk("rewrite write_collision_flag", FL, 32'h2);
		wait_val(FL, 32'h1, 32'h1);
		chk("rewrite byte", 8'h5a, got);
		// two receives, the second overflows; ack then decline
		for (i = 0; i < 2; i++) begin
			apb(1, FL, 32'hf);
			rd_mode <= 1;
			rd_byte <= i ? 8'h5e : 8'hc3;
			apb(1, CT, 32'h8);
			apb(1, BU, 32'h99);
			wait_val(FL, 32'h1, 32'h1);
			rdchk("rx flags", FL, i ? 32'h7 : 32'h3);
			rdchk("rx bf", ST, 32'h9);
			rdchk("rx ctrl", CT, 32'h0);
			rd_mode <= 0;
			ack_en <= 0; // the slave must not answer the master's own ack clock
			apb(1, CT, 32'h10 | (i << 5));
			wait_val(CT, 32'h10, 32'h0);
			chk("ack level", i, sda);
			chk("ack scl", 0, scl);
		end
		rdchk("rx byte", BU, 32'h5e);
		rdchk("bf read", ST, 32'h8);
		// stop
		apb(1, FL, 32'hf);
		apb(1, CT, 32'h4);
		wait_val(CT, 32'h4, 32'h0);
		rdchk("stop seen", ST, 32'h10);
		rdchk("stop irq", FL, 32'h1);
		chk("bus free", 2'b11, {scl, sda});
		// scl pulled low by another party before sda falls
		apb(1, FL, 32'hf);
		apb(1, CT, 32'h2);
		wait_scl(1);
		wait_scl(0);
		repeat (6) @(posedge pclk);
		hold_scl <= 1;
		repeat (10) @(posedge pclk);
		hold_scl <= 0;
		rdchk("collision", FL, 32'h8);
		rdchk("rs abort", CT, 32'h0);
		chk("col lines", 2'b00, {scl_oe, sda_oe});
		// reset in the middle of a receive
		apb(1, RL, 32'h0c);
		rdchk("reload", RL, 32'h0c);
		apb(1, CT, 32'h8);
		repeat (30) @(posedge pclk);
		presetn <= 0;
		repeat (2) @(posedge pclk);
		chk("reset lines", 2'b00, {scl_oe, sda_oe});
		presetn <= 1;
		rdchk("reload back", RL, `IMS_RELOAD_RESET);
		rdchk("ctrl back", CT, 32'h0);
		wrap_up;
	end
endmodule // ims_sequencer_tb_top
